// *** hw/ccss_pkg.sv ***
package ccss_pkg;
    // Register byte offsets on the AXI4-Lite bus
    localparam logic [7:0] OFS_MODE      = 8'h00;
    localparam logic [7:0] OFS_OSC_CTRL  = 8'h04;
    localparam logic [7:0] OFS_SYS_CLK   = 8'h08;
    localparam logic [7:0] OFS_CLK_SEL   = 8'h0c;
    localparam logic [7:0] OFS_SUB_MODE  = 8'h10;
    localparam logic [7:0] OFS_LOOP_CTRL = 8'h14;
    localparam logic [7:0] OFS_LOOP_STAT = 8'h18;
    localparam logic [7:0] OFS_POST_DIV  = 8'h1c;

    // Field positions
    localparam int unsigned SUB_OSC_STOP_BIT  = 6;
    localparam int unsigned FAST_OSC_STOP_BIT = 0;
    localparam int unsigned CPU_STAT_BIT      = 7;
    localparam int unsigned CPU_SEL_BIT       = 6;
    localparam int unsigned MAIN_STAT_BIT     = 5;
    localparam int unsigned MAIN_SEL_BIT      = 4;
    localparam int unsigned LOW_SPEED_BIT     = 0;
    localparam int unsigned RTC_LP_BIT        = 7;
    localparam int unsigned LOOP_ON_BIT       = 0;
    localparam int unsigned LOOP_SEL_BIT      = 6;
    localparam int unsigned LOCK_BIT          = 7;
    localparam int unsigned LOOP_SEL_STAT_BIT = 3;
    localparam int unsigned POST_DIV_W        = 3;

    // Reset values
    localparam logic [7:0] RST_MODE      = 8'h00;
    localparam logic [7:0] RST_OSC_CTRL  = 8'h40;
    localparam logic [7:0] RST_SYS_CLK   = 8'h00;
    localparam logic [7:0] RST_CLK_SEL   = 8'h00;
    localparam logic [7:0] RST_SUB_MODE  = 8'h00;
    localparam logic [7:0] RST_LOOP_CTRL = 8'h00;
    localparam logic [2:0] RST_POST_DIV  = 3'h0;

    // Byte-only strobe for the write-once mode register
    localparam logic [3:0] BYTE0_STRB = 4'h1;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Handover time for a glitch-free source change
    localparam int unsigned CLK_PERIOD_NS   = 8;
    localparam int unsigned HANDOVER_NS     = 64;
    localparam int unsigned HANDOVER_CYCLES =
        (HANDOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        SRC_FAST_ONCHIP,
        SRC_HS_SYSTEM,
        SRC_SUBSYSTEM,
        SRC_LOW_SPEED,
        SRC_LOOP
    } ccss_src_t;
endpackage

// *** hw/ccss_handover.sv ***
module ccss_handover #(
    parameter int unsigned SETTLE = ccss_pkg::HANDOVER_CYCLES
) (
    input  wire logic aclk,         // Clock
    input  wire logic aresetn,      // Sync reset, active low
    input  wire logic req,          // Requested source level
    input  wire logic target_ready, // Requested source is running
    output logic      status        // Source actually in use
);
    typedef struct packed {
        logic [7:0] cnt;
        logic       status;
    } ccss_ho_state_t;

    ccss_ho_state_t st_reg;
    ccss_ho_state_t st_next;

    // Old source stays reported until the new one has run for SETTLE cycles
    always_comb begin
        st_next = st_reg;
        if (req != st_reg.status && target_ready) begin
            if (st_reg.cnt == 8'(SETTLE - 1)) begin
                st_next.status = req; // see RULE_10
                st_next.cnt    = 8'h00;
            end else begin
                st_next.cnt = st_reg.cnt + 8'h01;
            end
        end else begin
            st_next.cnt = 8'h00;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign status = st_reg.status;
endmodule

// *** hw/ccss_switcher.sv ***
// Overview of operation
// RULE_01: Software sets RTC low power, clears low-speed select, programs mode, starts sub osc.
// RULE_02: After CPU select set, status reads 1 once CPU runs from sub/low clock.
// RULE_03: Low-speed path: software sets low-speed select, mode, then CPU select.
// RULE_04: Mode register takes one byte write after reset; later writes ignored.
// RULE_05: Software programs loop control and waits 1 us after multiplier write.
// RULE_06: Lock flag rises once loop locked while loop oscillator on.
// RULE_07: After lock and post divider, loop-selected status rises once CPU runs on loop.
// RULE_08: Clearing main select reports main status 0 after switch back to fast osc.
// RULE_09: Software waits 18-65 us or 18-105 us after fast osc restart.
// RULE_10: Status keeps old source until new one drives CPU; switch is glitch-free. Code: route lags status one cycle; sub/low choice skips handover.
//
// Local design decisions: the AXI4-Lite register port and the placing of the registers.
module ccss_switcher (
    input  wire logic        aclk,                // Clock, 125 MHz
    input  wire logic        aresetn,             // Sync reset, active low
    input  wire logic [31:0] s_axi_awaddr,        // Write address
    input  wire logic        s_axi_awvalid,       // Write address valid
    output logic             s_axi_awready,       // Write address ready
    input  wire logic [31:0] s_axi_wdata,         // Write data
    input  wire logic [3:0]  s_axi_wstrb,         // Write strobes
    input  wire logic        s_axi_wvalid,        // Write data valid
    output logic             s_axi_wready,        // Write data ready
    output logic [1:0]       s_axi_bresp,         // Write response
    output logic             s_axi_bvalid,        // Write response valid
    input  wire logic        s_axi_bready,        // Write response ready
    input  wire logic [31:0] s_axi_araddr,        // Read address
    input  wire logic        s_axi_arvalid,       // Read address valid
    output logic             s_axi_arready,       // Read address ready
    output logic [31:0]      s_axi_rdata,         // Read data
    output logic [1:0]       s_axi_rresp,         // Read response
    output logic             s_axi_rvalid,        // Read data valid
    input  wire logic        s_axi_rready,        // Read data ready
    input  wire logic        sub_osc_stable_pin,  // Subsystem osc stable
    input  wire logic        hs_sys_stable_pin,   // High-speed system osc stable
    input  wire logic        loop_lock_pin,       // Loop analog lock
    output logic [2:0]       cpu_clock_route,     // Source driving the CPU
    output logic             loop_osc_enable,     // Loop oscillator on
    output logic [2:0]       post_divider_out     // Main clock post divider
);
    typedef struct packed {
        logic        aw_held;
        logic [7:0]  aw_addr;
        logic        aw_bad;
        logic        w_held;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [7:0]  mode;
        logic        mode_written;
        logic [7:0]  osc_ctrl;
        logic [7:0]  sys_clk;
        logic [7:0]  clk_sel;
        logic [7:0]  sub_mode;
        logic [7:0]  loop_ctrl;
        logic [2:0]  post_div;
        logic [1:0]  sync_sub;
        logic [1:0]  sync_hs;
        logic [1:0]  sync_lock;
        logic [2:0]  route;
        logic        aw_rdy;
        logic        w_rdy;
        logic        ar_rdy;
    } ccss_state_t;

    ccss_state_t st_reg;
    ccss_state_t st_next;

    logic cpu_stat;
    logic main_stat;
    logic loop_stat;
    logic lock_flag;
    logic cpu_ready;
    logic main_ready;
    logic aw_fire;
    logic w_fire;
    logic do_write;
    logic mode_wr;

    // Sync stage order: [0] first flop, [1] second flop
    assign lock_flag = st_reg.loop_ctrl[ccss_pkg::LOOP_ON_BIT] && st_reg.sync_lock[1];
    assign cpu_ready = st_reg.clk_sel[ccss_pkg::LOW_SPEED_BIT]
                     || (!st_reg.osc_ctrl[ccss_pkg::SUB_OSC_STOP_BIT] && st_reg.sync_sub[1]);
    assign main_ready = st_reg.sys_clk[ccss_pkg::MAIN_SEL_BIT] ? st_reg.sync_hs[1]
                      : !st_reg.osc_ctrl[ccss_pkg::FAST_OSC_STOP_BIT];

    ccss_handover #(
        .SETTLE (ccss_pkg::HANDOVER_CYCLES)
    ) u_cpu_ho (
        .aclk         (aclk),
        .aresetn      (aresetn),
        .req          (st_reg.sys_clk[ccss_pkg::CPU_SEL_BIT]),
        .target_ready (st_reg.sys_clk[ccss_pkg::CPU_SEL_BIT] ? cpu_ready : 1'b1),
        .status       (cpu_stat)
    );

    ccss_handover #(
        .SETTLE (ccss_pkg::HANDOVER_CYCLES)
    ) u_main_ho (
        .aclk         (aclk),
        .aresetn      (aresetn),
        .req          (st_reg.sys_clk[ccss_pkg::MAIN_SEL_BIT]),
        .target_ready (main_ready),
        .status       (main_stat)
    );

    ccss_handover #(
        .SETTLE (ccss_pkg::HANDOVER_CYCLES)
    ) u_loop_ho (
        .aclk         (aclk),
        .aresetn      (aresetn),
        .req          (st_reg.loop_ctrl[ccss_pkg::LOOP_SEL_BIT]),
        .target_ready (st_reg.loop_ctrl[ccss_pkg::LOOP_SEL_BIT] ? lock_flag : 1'b1),
        .status       (loop_stat)
    );

    function automatic logic [2:0] route_of(input logic cpu_s, input logic main_s,
                                            input logic loop_s, input logic low_sel);
        if (cpu_s) begin
            route_of = low_sel ? 3'(ccss_pkg::SRC_LOW_SPEED) : 3'(ccss_pkg::SRC_SUBSYSTEM);
        end else if (loop_s) begin
            route_of = 3'(ccss_pkg::SRC_LOOP);
        end else if (main_s) begin
            route_of = 3'(ccss_pkg::SRC_HS_SYSTEM);
        end else begin
            route_of = 3'(ccss_pkg::SRC_FAST_ONCHIP);
        end
    endfunction

    assign aw_fire  = s_axi_awvalid && s_axi_awready;
    assign w_fire   = s_axi_wvalid && s_axi_wready;
    assign do_write = (st_reg.aw_held || aw_fire) && (st_reg.w_held || w_fire)
                   && !st_reg.bvalid;
    assign mode_wr  = do_write
                   && (st_reg.aw_held ? st_reg.aw_addr : s_axi_awaddr[7:0])
                      == ccss_pkg::OFS_MODE;

    always_comb begin
        logic [7:0]  wa;
        logic [31:0] wd;
        logic [3:0]  ws;
        logic [7:0]  ra;
        logic        wbad;
        wa = st_reg.aw_held ? st_reg.aw_addr : s_axi_awaddr[7:0];
        wd = st_reg.w_held ? st_reg.w_data : s_axi_wdata;
        ws = st_reg.w_held ? st_reg.w_strb : s_axi_wstrb;
        ra = s_axi_araddr[7:0];
        // Upper address bits are kept as a flag when the address arrives first
        wbad = st_reg.aw_held ? st_reg.aw_bad : (s_axi_awaddr[31:8] != 24'h000000);
        st_next = st_reg;

        st_next.sync_sub  = {st_reg.sync_sub[0], sub_osc_stable_pin};
        st_next.sync_hs   = {st_reg.sync_hs[0], hs_sys_stable_pin};
        st_next.sync_lock = {st_reg.sync_lock[0], loop_lock_pin};

        if (aw_fire) begin
            st_next.aw_held = 1'b1;
            st_next.aw_addr = s_axi_awaddr[7:0];
            st_next.aw_bad  = s_axi_awaddr[31:8] != 24'h000000;
        end
        if (w_fire) begin
            st_next.w_held = 1'b1;
            st_next.w_data = s_axi_wdata;
            st_next.w_strb = s_axi_wstrb;
        end
        if (st_reg.bvalid && s_axi_bready) begin
            st_next.bvalid = 1'b0;
        end

        if (do_write) begin
            st_next.aw_held = 1'b0;
            st_next.w_held  = 1'b0;
            st_next.bvalid  = 1'b1;
            st_next.bresp   = ccss_pkg::RESP_OKAY;
            if (wbad) begin
                st_next.bresp = ccss_pkg::RESP_SLVERR;
            end else if (wa == ccss_pkg::OFS_MODE) begin
                // Only the first byte-wide write counts
                if (!st_reg.mode_written && ws == ccss_pkg::BYTE0_STRB) begin // see RULE_04
                    st_next.mode         = wd[7:0];
                    st_next.mode_written = 1'b1;
                end
            end else if (wa == ccss_pkg::OFS_OSC_CTRL) begin
                if (ws[0]) st_next.osc_ctrl = wd[7:0];
            end else if (wa == ccss_pkg::OFS_SYS_CLK) begin
                if (ws[0]) begin
                    st_next.sys_clk[ccss_pkg::CPU_SEL_BIT]  = wd[ccss_pkg::CPU_SEL_BIT];
                    st_next.sys_clk[ccss_pkg::MAIN_SEL_BIT] = wd[ccss_pkg::MAIN_SEL_BIT];
                end
            end else if (wa == ccss_pkg::OFS_CLK_SEL) begin
                if (ws[0]) st_next.clk_sel = wd[7:0] & 8'h01;
            end else if (wa == ccss_pkg::OFS_SUB_MODE) begin
                if (ws[0]) st_next.sub_mode = wd[7:0] & 8'h80;
            end else if (wa == ccss_pkg::OFS_LOOP_CTRL) begin
                if (ws[0]) st_next.loop_ctrl = wd[7:0];
            end else if (wa == ccss_pkg::OFS_POST_DIV) begin
                if (ws[0]) st_next.post_div = wd[2:0];
            end else if (wa != ccss_pkg::OFS_LOOP_STAT) begin
                st_next.bresp = ccss_pkg::RESP_SLVERR;
            end
        end

        if (st_reg.rvalid && s_axi_rready) begin
            st_next.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            st_next.rvalid = 1'b1;
            st_next.rdata  = 32'h00000000;
            st_next.rresp  = ccss_pkg::RESP_OKAY;
            if (s_axi_araddr[31:8] != 24'h000000) begin
                st_next.rresp = ccss_pkg::RESP_SLVERR;
            end else if (ra == ccss_pkg::OFS_MODE) begin
                st_next.rdata[7:0] = st_reg.mode;
            end else if (ra == ccss_pkg::OFS_OSC_CTRL) begin
                st_next.rdata[7:0] = st_reg.osc_ctrl;
            end else if (ra == ccss_pkg::OFS_SYS_CLK) begin
                st_next.rdata[7:0] = st_reg.sys_clk;
                st_next.rdata[ccss_pkg::CPU_STAT_BIT]  = cpu_stat;  // see RULE_02
                st_next.rdata[ccss_pkg::MAIN_STAT_BIT] = main_stat; // see RULE_08
            end else if (ra == ccss_pkg::OFS_CLK_SEL) begin
                st_next.rdata[7:0] = st_reg.clk_sel;
            end else if (ra == ccss_pkg::OFS_SUB_MODE) begin
                st_next.rdata[7:0] = st_reg.sub_mode;
            end else if (ra == ccss_pkg::OFS_LOOP_CTRL) begin
                st_next.rdata[7:0] = st_reg.loop_ctrl;
            end else if (ra == ccss_pkg::OFS_LOOP_STAT) begin
                st_next.rdata[ccss_pkg::LOCK_BIT]          = lock_flag; // see RULE_06
                st_next.rdata[ccss_pkg::LOOP_SEL_STAT_BIT] = loop_stat; // see RULE_07
            end else if (ra == ccss_pkg::OFS_POST_DIV) begin
                st_next.rdata[2:0] = st_reg.post_div;
            end else begin
                st_next.rresp = ccss_pkg::RESP_SLVERR;
            end
        end

        // Route follows reported status; only the sub/low-speed choice comes straight from clk_sel
        st_next.route = route_of(cpu_stat, main_stat, loop_stat,
                                 st_reg.clk_sel[ccss_pkg::LOW_SPEED_BIT]); // see RULE_10

        // Readies taken from next state so bus outputs leave a flop
        st_next.aw_rdy = !st_next.aw_held && !st_next.bvalid;
        st_next.w_rdy  = !st_next.w_held && !st_next.bvalid;
        st_next.ar_rdy = !st_next.rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg           <= '0;
            st_reg.mode      <= ccss_pkg::RST_MODE;
            st_reg.osc_ctrl  <= ccss_pkg::RST_OSC_CTRL;
            st_reg.sys_clk   <= ccss_pkg::RST_SYS_CLK;
            st_reg.clk_sel   <= ccss_pkg::RST_CLK_SEL;
            st_reg.sub_mode  <= ccss_pkg::RST_SUB_MODE;
            st_reg.loop_ctrl <= ccss_pkg::RST_LOOP_CTRL;
            st_reg.post_div  <= ccss_pkg::RST_POST_DIV;
            st_reg.route     <= 3'(ccss_pkg::SRC_FAST_ONCHIP);
            st_reg.aw_rdy    <= 1'b1;
            st_reg.w_rdy     <= 1'b1;
            st_reg.ar_rdy    <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign s_axi_awready    = st_reg.aw_rdy;
    assign s_axi_wready     = st_reg.w_rdy;
    assign s_axi_bvalid     = st_reg.bvalid;
    assign s_axi_bresp      = st_reg.bresp;
    assign s_axi_arready    = st_reg.ar_rdy;
    assign s_axi_rvalid     = st_reg.rvalid;
    assign s_axi_rdata      = st_reg.rdata;
    assign s_axi_rresp      = st_reg.rresp;
    assign cpu_clock_route  = st_reg.route;
    assign loop_osc_enable  = st_reg.loop_ctrl[ccss_pkg::LOOP_ON_BIT];
    assign post_divider_out = st_reg.post_div;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_cpu_req_held;
        (st_reg.sys_clk[ccss_pkg::CPU_SEL_BIT] && cpu_ready && !cpu_stat) [*8];
    endsequence

    AST_MODE_ONCE: assert property ( // see RULE_04
        st_reg.mode_written |=> $stable(st_reg.mode) && st_reg.mode_written)
        else $error("mode register changed after first write");
    AST_MODE_BYTE: assert property ( // see RULE_04
        (mode_wr && !st_reg.mode_written
         && (st_reg.w_held ? st_reg.w_strb : s_axi_wstrb) != ccss_pkg::BYTE0_STRB)
        |=> !st_reg.mode_written)
        else $error("mode register took a non-byte write");
    AST_CPU_STAT: assert property ( // see RULE_02
        s_cpu_req_held |-> ##[0:2] cpu_stat)
        else $error("cpu status did not follow select");
    AST_CPU_CAUSE: assert property ( // see RULE_02
        $rose(cpu_stat) |-> $past(st_reg.sys_clk[ccss_pkg::CPU_SEL_BIT]) && $past(cpu_ready))
        else $error("cpu status rose without request");
    AST_LOCK: assert property ( // see RULE_06
        lock_flag == (st_reg.loop_ctrl[ccss_pkg::LOOP_ON_BIT] && $past(loop_lock_pin, 2)))
        else $error("lock flag does not follow synced lock pin");
    AST_LOOP_STAT: assert property ( // see RULE_07
        $rose(loop_stat) |-> $past(lock_flag) && $past(st_reg.loop_ctrl[ccss_pkg::LOOP_SEL_BIT]))
        else $error("loop status rose without lock");
    AST_MAIN_BACK: assert property ( // see RULE_08
        $fell(main_stat) |-> $past(!st_reg.sys_clk[ccss_pkg::MAIN_SEL_BIT])
                             && $past(!st_reg.osc_ctrl[ccss_pkg::FAST_OSC_STOP_BIT]))
        else $error("main status fell while fast osc stopped");
    AST_NO_EARLY: assert property ( // see RULE_10
        (!cpu_stat && !loop_stat) [*2] |-> st_reg.route != 3'(ccss_pkg::SRC_SUBSYSTEM)
                                   && st_reg.route != 3'(ccss_pkg::SRC_LOOP))
        else $error("route moved before status");
endmodule

// *** testbench/ccss_switcher_bench.sv ***
module ccss_switcher_bench;
    timeunit 1ns;
    timeprecision 1ps;

    logic        aclk    = 1'b0;
    logic        aresetn = 1'b0;
    logic [31:0] awaddr  = 32'h0;
    logic [31:0] wdata   = 32'h0;
    logic [31:0] araddr  = 32'h0;
    logic [3:0]  wstrb   = 4'h0;
    logic        awvalid = 1'b0;
    logic        wvalid  = 1'b0;
    logic        bready  = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready  = 1'b0;
    logic        sub_pin = 1'b0;
    logic        hs_pin  = 1'b0;
    logic        lock_pin = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, loop_en;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [2:0]  route, pdiv;
    int          fails = 0;
    int          tests_run = 0;

    always #4 aclk = ~aclk;

    ccss_switcher ccss_switcher_i (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .sub_osc_stable_pin(sub_pin), .hs_sys_stable_pin(hs_pin),
        .loop_lock_pin(lock_pin), .cpu_clock_route(route),
        .loop_osc_enable(loop_en), .post_divider_out(pdiv)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        if (fails == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Releases at the edge the answer is sampled, raises again one edge later
    task automatic wr(input logic [31:0] a, input logic [31:0] d,
                      input logic [3:0] s = 4'h1, input logic [1:0] er = 2'h0);
        int n;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid && n < 100);
        bready <= 1'b0;
        check({31'h0, bvalid}, 32'h1);
        check({30'h0, bresp}, {30'h0, er});
    endtask

    task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid && n < 100);
        rready <= 1'b0;
        d = rdata;
        r = rresp;
    endtask

    task automatic rchk(input logic [31:0] a, input logic [31:0] e,
                        input logic [1:0] er = 2'h0);
        logic [31:0] d;
        logic [1:0]  r;
        rd(a, d, r);
        check(d, e);
        check({30'h0, r}, {30'h0, er});
    endtask

    // Status bits need the handover time plus synchroniser delay
    task automatic poll(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        int          n;
        n = 0;
        do begin
            rd(a, d, r);
            n++;
        end while ((d & m) !== e && n < 40);
        check(d & m, e);
    endtask

    initial begin
        repeat (40000) @(posedge aclk);
        fails++;
        give_verdict();
    end

    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            rchk(32'(i * 4), (i == 1) ? 32'h40 : 32'h0);
        end
        check(32'(route), 32'(ccss_pkg::SRC_FAST_ONCHIP));
        // Write-once mode register: only a lone lane-0 write counts
        wr(32'h00, 32'h11, 4'hf);
        rchk(32'h00, 32'h00);
        wr(32'h00, 32'h10);
        rchk(32'h00, 32'h10);
        wr(32'h00, 32'h33);
        rchk(32'h00, 32'h10);
        wr(32'h20, 32'h01, 4'h1, 2'h2);
        rchk(32'h20, 32'h0, 2'h2);
        rchk(32'h108, 32'h0, 2'h2);
        wr(32'h18, 32'hff);
        rchk(32'h18, 32'h00);
        wr(32'h1c, 32'h07, 4'h0);
        rchk(32'h1c, 32'h00);
        // Main select waits for the high-speed oscillator
        wr(32'h08, 32'h10);
        repeat (30) @(posedge aclk);
        rchk(32'h08, 32'h10);
        hs_pin <= 1'b1;
        poll(32'h08, 32'h20, 32'h20);
        check(32'(route), 32'(ccss_pkg::SRC_HS_SYSTEM));
        // Return with fast oscillator stopped: must hold until restarted
        wr(32'h04, 32'h41);
        wr(32'h08, 32'h00);
        repeat (30) @(posedge aclk);
        rchk(32'h08, 32'h20);
        wr(32'h04, 32'h40);
        repeat (2250) @(posedge aclk);
        poll(32'h08, 32'h20, 32'h00);
        check(32'(route), 32'(ccss_pkg::SRC_FAST_ONCHIP));
        // Loop clock path
        wr(32'h14, 32'hb6);
        repeat (125) @(posedge aclk);
        wr(32'h14, 32'hb7);
        repeat (2) @(posedge aclk);
        check({31'h0, loop_en}, 32'h1);
        rchk(32'h18, 32'h00);
        lock_pin <= 1'b1;
        poll(32'h18, 32'h80, 32'h80);
        wr(32'h1c, 32'h05);
        repeat (2) @(posedge aclk);
        check({29'h0, pdiv}, 32'h5);
        wr(32'h14, 32'hf7);
        poll(32'h18, 32'h08, 32'h08);
        rchk(32'h18, 32'h88);
        check(32'(route), 32'(ccss_pkg::SRC_LOOP));
        wr(32'h14, 32'h00);
        poll(32'h18, 32'hff, 32'h00);
        lock_pin <= 1'b0;
        check({31'h0, loop_en}, 32'h0);
        check(32'(route), 32'(ccss_pkg::SRC_FAST_ONCHIP));
        // Subsystem clock sequence
        wr(32'h10, 32'h80);
        wr(32'h0c, 32'h00);
        wr(32'h04, 32'h00);
        wr(32'h08, 32'h40);
        repeat (30) @(posedge aclk);
        rchk(32'h08, 32'h40);
        sub_pin <= 1'b1;
        poll(32'h08, 32'h80, 32'h80);
        check(32'(route), 32'(ccss_pkg::SRC_SUBSYSTEM));
        wr(32'h08, 32'h00);
        poll(32'h08, 32'h80, 32'h00);
        // Low-speed oscillator sequence, sub oscillator stopped
        wr(32'h04, 32'h40);
        sub_pin <= 1'b0;
        wr(32'h0c, 32'h01);
        wr(32'h08, 32'h40);
        poll(32'h08, 32'h80, 32'h80);
        check(32'(route), 32'(ccss_pkg::SRC_LOW_SPEED));
        // Mid-run reset returns to defaults and re-arms the write-once register
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        check({31'h0, arready}, 32'h1);
        check(32'(route), 32'(ccss_pkg::SRC_FAST_ONCHIP));
        rchk(32'h08, 32'h00);
        rchk(32'h0c, 32'h00);
        rchk(32'h00, 32'h00);
        wr(32'h00, 32'h22);
        rchk(32'h00, 32'h22);
        give_verdict();
    end
endmodule
